// ==== core/brc_map.vh ====
// brc_map.vh: register addresses, field positions and reset values for the
// boost and restart configuration bank.
// assumes inclusion by the design files only; holds definitions, no logic.
`ifndef BRC_MAP_VH
`define BRC_MAP_VH

// ----------------------------------------------------------------------------
// bus widths and addresses
// ----------------------------------------------------------------------------
`define BRC_AW              8
`define BRC_DW              8
`define BRC_FAULT_ADDR      8'h12
`define BRC_RATIO_ADDR      8'h14
`define BRC_PRIM_ADDR       8'h15
`define BRC_SEC_ADDR        8'h16
`define BRC_RESTART_ADDR    8'hff
`define BRC_RESTART_KEY     8'h00
`define BRC_READ_ZERO       8'h00

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define BRC_FAULT_RST       8'h30
`define BRC_RATIO_RST       8'h11
`define BRC_PRIM_RST        8'h03
`define BRC_SEC_RST         8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BRC_DRV_HI          7
`define BRC_DRV_LO          6
`define BRC_DSCG_BIT        2
`define BRC_SKIP_BIT        1
`define BRC_RATE_BIT        0
`define BRC_POLICY_BIT      3
`define BRC_GM_HI           1
`define BRC_GM_LO           0
`define BRC_AUTO_BIT        4
`define BRC_MCS_HI          3
`define BRC_MCS_LO          0
`define BRC_TRIG_BIT        3
`define BRC_POL_HI          2
`define BRC_POL_LO          0
`define BRC_FAULTS          4

`endif

// ==== core/brc_restart.v ====
// brc_restart.v: watches the write port for the restart key at the restart
// address and issues a one-cycle restart pulse.
// assumes writes are synchronous to i_clk and qualified by i_ce.
`timescale 1ns/1ps
`include "brc_map.vh"

module brc_restart (
	// clock and reset
	input  wire                  i_clk,
	input  wire                  i_reset,
	input  wire                  i_ce,
	// write port
	input  wire                  i_wr_en,
	input  wire [`BRC_AW-1:0]    i_wr_addr,
	input  wire [`BRC_DW-1:0]    i_wr_data,
	// restart pulse
	output wire                  o_restart
);

	reg restart_q;

	// ------------------------------------------------------------------------
	// key detection
	// ------------------------------------------------------------------------
	// only the exact key starts a restart; other values are dropped silently
	// the restart cycle discards every write, a repeated key included, so one
	// restart never stretches into a second pulse
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			restart_q <= 1'b0;
		end else if (i_ce) begin
			restart_q <= i_wr_en && !restart_q && (i_wr_addr == `BRC_RESTART_ADDR)
				&& (i_wr_data == `BRC_RESTART_KEY);
		end
	end

	assign o_restart = restart_q;

endmodule

// ==== core/brc_recovery.v ====
// brc_recovery.v: turns a write of the manual recovery trigger into one
// recovery attempt pulse per fault whose policy selects manual recovery.
// assumes the policy vector is stable during the trigger write.
`timescale 1ns/1ps
`include "brc_map.vh"

module brc_recovery (
	// clock and reset
	input  wire                     i_clk,
	input  wire                     i_reset,
	input  wire                     i_ce,
	// trigger and policies
	input  wire                     i_trigger,
	input  wire [`BRC_FAULTS-1:0]   i_policy_manual,
	// attempt pulses
	output wire [`BRC_FAULTS-1:0]   o_attempt
);

	reg [`BRC_FAULTS-1:0] attempt_q;

	// ------------------------------------------------------------------------
	// per-fault attempt pulses
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `BRC_FAULTS; g = g + 1) begin : g_fault
			// auto-recovered faults ignore the trigger
			always @(posedge i_clk or posedge i_reset) begin
				if (i_reset) begin
					attempt_q[g] <= 1'b0;
				end else if (i_ce) begin
					attempt_q[g] <= i_trigger & i_policy_manual[g];
				end
			end
		end
	endgenerate

	assign o_attempt = attempt_q;

endmodule

// ==== core/brc_regs.v ====
// brc_regs.v: boost and restart configuration bank; fault recovery, clock
// ratio and both boost setting registers, plus the restart trigger.
// assumes a synchronous internal register port from the serial host logic
// and an analog boost stage consuming the setting outputs as levels.
`timescale 1ns/1ps
`include "brc_map.vh"

module brc_regs (
	// clock, reset, enable
	input  wire                     i_clk,
	input  wire                     i_reset,
	input  wire                     i_ce,
	// register write port
	input  wire                     i_wr_en,
	input  wire [`BRC_AW-1:0]       i_wr_addr,
	input  wire [`BRC_DW-1:0]       i_wr_data,
	// register read port
	input  wire                     i_rd_en,
	input  wire [`BRC_AW-1:0]       i_rd_addr,
	output wire [`BRC_DW-1:0]       o_rd_data,
	// clock ratio detector
	input  wire                     i_detect_valid,
	input  wire [3:0]               i_detect_ratio,
	// boost settings
	output wire [1:0]               o_high_side_drive_speed,
	output wire                     o_output_discharge_enable,
	output wire                     o_pulse_skip_allow,
	output wire                     o_switching_rate_select,
	output wire                     o_converter_fault_recovery_policy,
	output wire [1:0]               o_error_amp_gain_select,
	// clocking settings
	output wire [3:0]               o_master_clock_ratio_field,
	output wire                     o_ratio_autodetect_enable,
	// recovery and restart
	output wire [`BRC_FAULTS-1:0]   o_recover_attempt,
	output wire                     o_soft_reset
);

	// ------------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------------
	reg  [`BRC_DW-1:0] fault_q;
	reg  [`BRC_DW-1:0] ratio_q;
	reg  [`BRC_DW-1:0] prim_q;
	reg  [`BRC_DW-1:0] sec_q;
	reg  [`BRC_DW-1:0] rd_data_q;
	reg  [`BRC_DW-1:0] rd_data_d;
	wire               restart;
	wire               trig_write;
	wire [`BRC_FAULTS-1:0] policy_manual;

	// address match, shared by write and read decode
	function hit;
		input [`BRC_AW-1:0] addr;
		input [`BRC_AW-1:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// ------------------------------------------------------------------------
	// restart detection
	// ------------------------------------------------------------------------
	brc_restart u_restart (
		.i_clk     (i_clk),
		.i_reset   (i_reset),
		.i_ce      (i_ce),
		.i_wr_en   (i_wr_en),
		.i_wr_addr (i_wr_addr),
		.i_wr_data (i_wr_data),
		.o_restart (restart)
	);

	// ------------------------------------------------------------------------
	// fault recovery register
	// ------------------------------------------------------------------------
	// trigger bit is write-only and never stored, so it reads back zero
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			fault_q <= `BRC_FAULT_RST;
		end else if (i_ce) begin
			if (restart) begin
				fault_q <= `BRC_FAULT_RST;
			end else if (i_wr_en && hit(i_wr_addr, `BRC_FAULT_ADDR)) begin
				fault_q <= i_wr_data & ~(8'h01 << `BRC_TRIG_BIT);
			end
		end
	end

	assign trig_write = i_ce && !restart && i_wr_en && hit(i_wr_addr, `BRC_FAULT_ADDR)
		&& i_wr_data[`BRC_TRIG_BIT];
	// boost fault policy lives in the secondary register, the rest here
	assign policy_manual = {sec_q[`BRC_POLICY_BIT], fault_q[`BRC_POL_HI:`BRC_POL_LO]};

	brc_recovery u_recovery (
		.i_clk           (i_clk),
		.i_reset         (i_reset),
		.i_ce            (i_ce),
		.i_trigger       (trig_write),
		.i_policy_manual (policy_manual),
		.o_attempt       (o_recover_attempt)
	);

	// ------------------------------------------------------------------------
	// clock ratio register
	// ------------------------------------------------------------------------
	// detector update beats a host write in the same cycle so the readback
	// shows what hardware found in that cycle while auto mode is on
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ratio_q <= `BRC_RATIO_RST;
		end else if (i_ce) begin
			if (restart) begin
				ratio_q <= `BRC_RATIO_RST;
			end else begin
				if (i_wr_en && hit(i_wr_addr, `BRC_RATIO_ADDR)) begin
					ratio_q <= i_wr_data;
				end
				if (ratio_q[`BRC_AUTO_BIT] && i_detect_valid) begin
					ratio_q[`BRC_MCS_HI:`BRC_MCS_LO] <= i_detect_ratio;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// boost setting registers
	// ------------------------------------------------------------------------
	// reserved bits are stored and read back but drive nothing
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			prim_q <= `BRC_PRIM_RST;
			sec_q  <= `BRC_SEC_RST;
		end else if (i_ce) begin
			if (restart) begin
				prim_q <= `BRC_PRIM_RST;
				sec_q  <= `BRC_SEC_RST;
			end else if (i_wr_en) begin
				if (hit(i_wr_addr, `BRC_PRIM_ADDR)) begin
					prim_q <= i_wr_data;
				end
				if (hit(i_wr_addr, `BRC_SEC_ADDR)) begin
					sec_q <= i_wr_data;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// setting outputs
	// ------------------------------------------------------------------------
	assign o_high_side_drive_speed           = prim_q[`BRC_DRV_HI:`BRC_DRV_LO];
	assign o_output_discharge_enable         = prim_q[`BRC_DSCG_BIT];
	assign o_pulse_skip_allow                = prim_q[`BRC_SKIP_BIT];
	assign o_switching_rate_select           = prim_q[`BRC_RATE_BIT];
	assign o_converter_fault_recovery_policy = sec_q[`BRC_POLICY_BIT];
	assign o_error_amp_gain_select           = sec_q[`BRC_GM_HI:`BRC_GM_LO];
	assign o_master_clock_ratio_field        = ratio_q[`BRC_MCS_HI:`BRC_MCS_LO];
	assign o_ratio_autodetect_enable         = ratio_q[`BRC_AUTO_BIT];
	assign o_soft_reset                      = restart;

	// ------------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------------
	// unmapped and restart addresses read zero
	always @* begin
		rd_data_d = `BRC_READ_ZERO;
		if (hit(i_rd_addr, `BRC_FAULT_ADDR)) begin
			rd_data_d = fault_q;
		end else if (hit(i_rd_addr, `BRC_RATIO_ADDR)) begin
			rd_data_d = ratio_q;
		end else if (hit(i_rd_addr, `BRC_PRIM_ADDR)) begin
			rd_data_d = prim_q;
		end else if (hit(i_rd_addr, `BRC_SEC_ADDR)) begin
			rd_data_d = sec_q;
		end
	end

	// read data holds until the next read
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_data_q <= `BRC_READ_ZERO;
		end else if (i_ce && i_rd_en) begin
			rd_data_q <= rd_data_d;
		end
	end

	assign o_rd_data = rd_data_q;

endmodule

// ==== tb/brc_regs_assertions.sv ====
// brc_regs_assertions.sv: timing checks on the boost and restart bank ports.
// assumes binding onto brc_regs; i_clk rising edge, i_reset async high.
`timescale 1ns/1ps
module brc_regs_chk (
	input wire       i_clk, i_reset, i_ce, i_wr_en, i_rd_en, i_detect_valid,
	input wire [7:0] i_wr_addr, i_wr_data, i_rd_addr, o_rd_data,
	input wire [3:0] i_detect_ratio, o_master_clock_ratio_field, o_recover_attempt,
	input wire [1:0] o_high_side_drive_speed, o_error_amp_gain_select,
	input wire       o_output_discharge_enable, o_pulse_skip_allow, o_switching_rate_select,
	input wire       o_converter_fault_recovery_policy, o_ratio_autodetect_enable, o_soft_reset
);
	// ------------------------------------------------------------------
	// write qualifiers; the restart cycle throws writes away
	// ------------------------------------------------------------------
	wire       wp    = i_ce & i_wr_en & ~o_soft_reset;
	wire       w15   = wp & (i_wr_addr == 8'h15);
	wire       w16   = wp & (i_wr_addr == 8'h16);
	wire       wkey  = wp & (i_wr_addr == 8'hff) & (i_wr_data == 8'h00);
	wire       wtrig = wp & (i_wr_addr == 8'h12) & i_wr_data[3];
	wire [4:0] boost = {o_high_side_drive_speed, o_output_discharge_enable, o_pulse_skip_allow,
		o_switching_rate_select};
	wire [2:0] sec   = {o_converter_fault_recovery_policy, o_error_amp_gain_select};
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	chk_drive_speed: assert property (w15 |=> o_high_side_drive_speed == $past(i_wr_data[7:6]))
		else $error("drive speed not taken from write");
	chk_discharge_bit: assert property (w15 |=> o_output_discharge_enable == $past(i_wr_data[2]))
		else $error("discharge enable not taken from write");
	chk_skip_rate: assert property (w15 |=> boost[1:0] == $past(i_wr_data[1:0]))
		else $error("mode or rate bit not taken from write");
	chk_second_fields: assert property (
		w16 |=> sec == {$past(i_wr_data[3]), $past(i_wr_data[1:0])})
		else $error("secondary fields not taken from write");
	chk_restart_pulse: assert property (wkey |=> o_soft_reset ##1 !o_soft_reset)
		else $error("restart pulse missing or too long");
	chk_restart_cause: assert property (o_soft_reset |-> $past(wkey))
		else $error("restart pulse without key write");
	chk_restart_restore: assert property (o_soft_reset |=> boost == 5'h03 && sec == 3'h0)
		else $error("settings not restored by restart");
	chk_settings_hold: assert property (!(w15 | w16 | o_soft_reset) |=> $stable(boost) && $stable(sec))
		else $error("settings moved without a write");
	chk_attempt_boost: assert property (
		wtrig |=> o_recover_attempt[3] == $past(o_converter_fault_recovery_policy))
		else $error("boost recovery attempt wrong");
	chk_attempt_cause: assert property (|o_recover_attempt |-> $past(wtrig))
		else $error("recovery attempt without trigger");
	chk_ratio_detect: assert property (
		i_ce && i_detect_valid && o_ratio_autodetect_enable && !o_soft_reset
		|=> o_master_clock_ratio_field == $past(i_detect_ratio))
		else $error("detected ratio not loaded");
	cover property (wkey);
	cover property (wtrig ##1 o_recover_attempt[3]);
	cover property (w15 ##1 w16);
endmodule
bind brc_regs brc_regs_chk u_brc_regs_chk (.i_clk, .i_reset, .i_ce, .i_wr_en, .i_rd_en, .i_detect_valid,
	.i_wr_addr, .i_wr_data, .i_rd_addr, .o_rd_data, .i_detect_ratio, .o_master_clock_ratio_field,
	.o_recover_attempt, .o_high_side_drive_speed, .o_error_amp_gain_select, .o_output_discharge_enable,
	.o_pulse_skip_allow, .o_switching_rate_select, .o_converter_fault_recovery_policy,
	.o_ratio_autodetect_enable, .o_soft_reset);

// ==== tb/brc_host_model.sv ====
// brc_host_model.sv: serial host stand-in for the internal register port.
// assumes the bench calls its tasks; drives only on the falling edge.
`timescale 1ns/1ps
module brc_host_model (
	input  wire        i_clk,
	input  wire  [7:0] i_rd_data,
	output logic       o_wr_en, o_rd_en,
	output logic [7:0] o_wr_addr, o_wr_data, o_rd_addr
);
	// ------------------------------------------------------------------
	// port idles quiet, address and data lines start at junk
	// ------------------------------------------------------------------
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_wr_addr = 8'h5a;
		o_wr_data = 8'ha5;
		o_rd_addr = 8'h5a;
	end
	// one write held over its edge; no restart except by this key path
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_wr_en = 1'b1;
		o_wr_addr = a;
		o_wr_data = d;
		@(posedge i_clk);
	endtask
	// release: lines flip so a stale value can never pass for a write
	task automatic idle();
		@(negedge i_clk);
		o_wr_en = 1'b0;
		o_wr_addr = ~o_wr_addr;
		o_wr_data = ~o_wr_data;
	endtask
	// one read; data stands after the taking edge, picked up a half cycle on
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_wr_en = 1'b0;
		o_rd_en = 1'b1;
		o_rd_addr = a;
		@(negedge i_clk);
		o_rd_en = 1'b0;
		o_rd_addr = ~a;
		d = i_rd_data;
	endtask
endmodule

// ==== tb/tb_top.sv ====
// tb_top.sv: directed register tests for the boost and restart bank.
// assumes brc_regs, its map header, checker and host model compiled first.
`timescale 1ns/1ps
module tb_top;
	logic       i_clk, i_reset, i_ce, dv;
	logic [3:0] dr;
	wire  [7:0] wa, wd, ra, rdat;
	wire        we, re, dsc, skip, rate, pol, aen, srst;
	wire  [1:0] spd, gm;
	wire  [3:0] ratio, att;
	logic [7:0] v, w;
	int         miscompares, compares, srst_cnt, k;
	brc_regs u_brc_regs (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_wr_en(we), .i_wr_addr(wa),
		.i_wr_data(wd), .i_rd_en(re), .i_rd_addr(ra), .o_rd_data(rdat), .i_detect_valid(dv),
		.i_detect_ratio(dr), .o_high_side_drive_speed(spd), .o_output_discharge_enable(dsc),
		.o_pulse_skip_allow(skip), .o_switching_rate_select(rate), .o_converter_fault_recovery_policy(pol),
		.o_error_amp_gain_select(gm), .o_master_clock_ratio_field(ratio), .o_ratio_autodetect_enable(aen),
		.o_recover_attempt(att), .o_soft_reset(srst));
	brc_host_model u_brc_host_model (.i_clk(i_clk), .i_rd_data(rdat), .o_wr_en(we), .o_rd_en(re),
		.o_wr_addr(wa), .o_wr_data(wd), .o_rd_addr(ra));
	// ------------------------------------------------------------------
	// clock, restart pulse counter, compare helpers
	// ------------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (srst === 1'b1) srst_cnt++;
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_brc_host_model.rd(a, v);
		chk($sformatf("reg %h", a), v, exp);
	endtask
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// watchdog well past the hundred or so cycles the tests take
	initial begin
		#200us;
		miscompares++;
		summarize();
	end
	initial begin
		i_reset = 1'b1;
		i_ce = 1'b1;
		dv = 1'b0;
		dr = 4'h0;
		repeat (20) @(negedge i_clk);
		i_reset = 1'b0;
		rchk(8'h15, 8'h03);
		rchk(8'h16, 8'h00);
		rchk(8'hff, 8'h00);
		rchk(8'h40, 8'h00);
		rchk(8'h14, 8'h11);
		// every drive speed and gain code, reserved bits stored too
		for (k = 0; k < 4; k++) begin
			w = {k[1:0], 3'b101, k[0], k[1], ~k[0]};
			u_brc_host_model.wr(8'h15, w);
			u_brc_host_model.wr(8'h16, {4'ha, k[0], 1'b1, k[1:0]});
			u_brc_host_model.idle();
			chk("primary", {3'b0, spd, dsc, skip, rate}, {3'b0, w[7:6], w[2:0]});
			chk("secondary", {5'b0, pol, gm}, {5'b0, k[0], k[1:0]});
			rchk(8'h15, w);
			rchk(8'h16, {4'ha, k[0], 1'b1, k[1:0]});
		end
		// back-to-back trigger uses the policies from before the write
		u_brc_host_model.wr(8'h12, 8'h05);
		u_brc_host_model.wr(8'h12, 8'h08);
		u_brc_host_model.idle();
		chk("attempt", {4'b0, att}, 8'h0d);
		rchk(8'h12, 8'h00);
		// detector loads only while autodetect is on
		@(negedge i_clk) dv = 1'b1;
		dr = 4'h9;
		@(negedge i_clk) dv = 1'b0;
		chk("ratio", {4'b0, ratio}, 8'h09);
		rchk(8'h14, 8'h19);
		u_brc_host_model.wr(8'h14, 8'h05);
		u_brc_host_model.idle();
		dv = 1'b1;
		@(negedge i_clk) dv = 1'b0;
		rchk(8'h14, 8'h05);
		// wrong key ignored, right key restarts and eats the next write
		k = srst_cnt;
		u_brc_host_model.wr(8'hff, 8'h01);
		u_brc_host_model.idle();
		chk("restart", 8'(srst_cnt - k), 8'h00);
		u_brc_host_model.wr(8'hff, 8'h00);
		u_brc_host_model.wr(8'h15, 8'hc0);
		u_brc_host_model.idle();
		chk("restart", 8'(srst_cnt - k), 8'h01);
		rchk(8'h15, 8'h03);
		rchk(8'h16, 8'h00);
		rchk(8'h14, 8'h11);
		rchk(8'h12, 8'h30);
		// a key repeated inside the restart cycle is thrown away like any write
		k = srst_cnt;
		u_brc_host_model.wr(8'hff, 8'h00);
		u_brc_host_model.wr(8'hff, 8'h00);
		u_brc_host_model.idle();
		chk("restart twice", 8'(srst_cnt - k), 8'h01);
		// clock enable low: a write held across its edge is not taken
		i_ce = 1'b0;
		u_brc_host_model.wr(8'h16, 8'h0b);
		u_brc_host_model.idle();
		i_ce = 1'b1;
		rchk(8'h16, 8'h00);
		summarize();
	end
endmodule
